// File: rtl/vct_timing.sv
// crt horizontal timing generator with its index/data register port
//
// How it works
// - port pair decodes at 3Bx when colour select is 0, 3Dx when 1.
// - index bits 4:0 select the register; bits 7:5 are reserved.
// - hsync-to-hsync period is programmed total plus 5 character clocks.
// - active display lasts display-end value plus 1 character clocks.
// - panel lock blocks writes to display end and vertical display-end bit 9.
// - active-low blank asserts when counter reaches blank-start value.
// - blank end is six bits: low five plus sync-end bit 7.
// - display enable skew codes give 0, 1, 2, 2 character clocks.
// - hsync goes active when counter equals sync-start value.
// - hsync goes inactive when counter low five bits match sync end.
// - hsync skew codes give 0, 1, 2, 3 character clocks.
// - frame period is 11-bit vertical total plus 2 scan lines.
// - overflow bits 7..4: vsync start 9, display end 9, total 9, compare 8.
// - overflow bits 3..0: vblank start 8, vsync start 8, display end 8, total 8.
// - write lock blocks writes to indices 0..7, except overflow bit 4.
`timescale 1ns/10ps
module vct_timing (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_char_en,
  input  wire logic        i_color_sel,
  input  wire logic        i_panel_lock,
  input  wire logic        i_timing_write_lock,
  input  wire logic        i_vtotal_bit10,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic             o_io_hit,
  output logic [7:0]       o_io_rdata,
  output logic             o_io_ack,
  output logic             o_hsync,
  output logic             o_blank_n,
  output logic             o_display_en,
  output logic             o_frame_start,
  output logic [11:0]      o_line_count,
  output logic [10:0]      o_vtotal,
  output logic [9:0]       o_vsync_start_high,
  output logic [9:0]       o_vdisplay_end_high,
  output logic             o_vblank_start_high_bit,
  output logic             o_line_compare_high_bit
);
  import vct_pkg::*;

  typedef struct packed {
    logic [7:0]                    idx;
    logic [NUM_REGS-1:0][7:0]      regs;
    logic [8:0]                    hcnt;
    logic [11:0]                   vcnt;
    logic                          hsync;
    logic                          blank_n;
    logic                          hde;
    logic                          frame_start;
    logic [7:0]                    rdata;
    logic                          ack;
  } vct_state_s;

  vct_state_s state_reg;
  vct_state_s state_next;

  logic [15:0] addr_index;
  logic [15:0] addr_data;
  logic        sel_index;
  logic        sel_data;
  logic        data_mapped;
  logic [2:0]  ridx;
  logic [7:0]  wmask;
  logic [8:0]  hlast;
  logic [11:0] vlast;
  logic [5:0]  hblank_end;
  logic [1:0]  hsync_skew;
  logic [1:0]  de_skew;
  logic        line_end;

  // address decode follows the colour/mono select
  always_comb begin
    addr_index = i_color_sel ? IO_COLOR_INDEX : IO_MONO_INDEX;
    addr_data  = i_color_sel ? IO_COLOR_DATA  : IO_MONO_DATA;
    sel_index  = (i_io_addr == addr_index);
    sel_data   = (i_io_addr == addr_data);
    ridx       = state_reg.idx[2:0];
    // only indices below eight live here; others belong to other blocks
    data_mapped = sel_data && (state_reg.idx[4:0] < 5'(NUM_REGS));
    o_io_hit   = sel_index || data_mapped;
  end

  // write masks for the two locks
  always_comb begin
    wmask = WMASK_ALL;
    if (i_timing_write_lock) begin
      wmask = (state_reg.idx[4:0] == IDX_VOVF) ? WMASK_LOCKED7 : WMASK_NONE;
    end
    if (i_panel_lock) begin
      if (state_reg.idx[4:0] == IDX_HDE) begin
        wmask = WMASK_NONE;
      end else if (state_reg.idx[4:0] == IDX_VOVF) begin
        wmask[OVF_VDE9_BIT] = 1'b0;
      end
    end
  end

  // field assembly
  always_comb begin
    hlast      = 9'({1'b0, state_reg.regs[IDX_HTOTAL[2:0]]} + HTOTAL_ADD - 9'h001);
    hblank_end = {state_reg.regs[IDX_HSE[2:0]][HBE_MSB_BIT],
                  state_reg.regs[IDX_HBE[2:0]][4:0]};
    hsync_skew = state_reg.regs[IDX_HSE[2:0]][SKEW_LSB+1:SKEW_LSB];
    de_skew    = state_reg.regs[IDX_HBE[2:0]][SKEW_LSB+1:SKEW_LSB];
    if (de_skew > DE_SKEW_MAX) begin
      de_skew = DE_SKEW_MAX;
    end
    o_vtotal = {i_vtotal_bit10,
                state_reg.regs[IDX_VOVF[2:0]][OVF_VT9_BIT],
                state_reg.regs[IDX_VOVF[2:0]][OVF_VT8_BIT],
                state_reg.regs[IDX_VTOTAL[2:0]]};
    vlast    = 12'({1'b0, o_vtotal} + VTOTAL_ADD - 12'h001);
    line_end = i_char_en && (state_reg.hcnt == hlast);
  end

  always_comb begin
    state_next             = state_reg;
    state_next.ack         = 1'b0;
    state_next.frame_start = 1'b0;

    // register port
    if (i_io_wr && sel_index) begin
      state_next.idx = i_io_wdata & INDEX_MASK;
    end else if (i_io_wr && data_mapped) begin
      state_next.regs[ridx] = (state_reg.regs[ridx] & ~wmask) | (i_io_wdata & wmask);
    end
    if (i_io_rd && o_io_hit) begin
      state_next.ack   = 1'b1;
      state_next.rdata = sel_index ? state_reg.idx : state_reg.regs[ridx];
    end

    // one character counter serves every horizontal compare
    if (i_char_en) begin
      state_next.hcnt = line_end ? '0 : 9'(state_reg.hcnt + 9'h001);
      if (state_next.hcnt[7:0] == state_reg.regs[IDX_HSS[2:0]] && !state_next.hcnt[8]) begin
        state_next.hsync = 1'b1;
      end else if (state_next.hcnt[4:0] == state_reg.regs[IDX_HSE[2:0]][4:0]) begin
        state_next.hsync = 1'b0;
      end
      if (state_next.hcnt[7:0] == state_reg.regs[IDX_HBS[2:0]] && !state_next.hcnt[8]) begin
        state_next.blank_n = 1'b0;
      end else if (state_next.hcnt[5:0] == hblank_end) begin
        state_next.blank_n = 1'b1;
      end
      state_next.hde = (state_next.hcnt <= {1'b0, state_reg.regs[IDX_HDE[2:0]]});
    end

    // scan line counter wraps after total plus two lines
    if (line_end) begin
      if (state_reg.vcnt >= vlast) begin
        state_next.vcnt        = '0;
        state_next.frame_start = 1'b1;
      end else begin
        state_next.vcnt = 12'(state_reg.vcnt + 12'h001);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_reg         <= '0;
      state_reg.idx     <= INDEX_RESET;
      state_reg.regs    <= {NUM_REGS{REG_RESET}};
      state_reg.blank_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // skews move the pulses, not the counter, so all compares stay aligned
  vct_skew #(
    .DEPTH(SKEW_DEPTH)
  ) u_hsync_skew (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_char_en (i_char_en),
    .i_din     (state_reg.hsync),
    .i_sel     (hsync_skew),
    .o_dout    (o_hsync)
  );

  vct_skew #(
    .DEPTH(SKEW_DEPTH)
  ) u_de_skew (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_char_en (i_char_en),
    .i_din     (state_reg.hde),
    .i_sel     (de_skew),
    .o_dout    (o_display_en)
  );

  always_comb begin
    o_io_rdata    = state_reg.rdata;
    o_io_ack      = state_reg.ack;
    o_blank_n     = state_reg.blank_n;
    o_frame_start = state_reg.frame_start;
    o_line_count  = state_reg.vcnt;
    o_vsync_start_high   = {state_reg.regs[IDX_VOVF[2:0]][OVF_VSS9_BIT],
                            state_reg.regs[IDX_VOVF[2:0]][OVF_VSS8_BIT], 8'h00};
    o_vdisplay_end_high  = {state_reg.regs[IDX_VOVF[2:0]][OVF_VDE9_BIT],
                            state_reg.regs[IDX_VOVF[2:0]][OVF_VDE8_BIT], 8'h00};
    o_vblank_start_high_bit = state_reg.regs[IDX_VOVF[2:0]][OVF_VBS8_BIT];
    o_line_compare_high_bit = state_reg.regs[IDX_VOVF[2:0]][OVF_LC8_BIT];
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  logic [8:0]            hs_gap;
  logic                  hs_seen;
  logic [8:0]            de_run;
  logic                  de_seen;
  logic [SKEW_DEPTH-1:0] hs_hist;
  logic [SKEW_DEPTH-1:0] de_hist;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      hs_gap  <= '0;
      hs_seen <= 1'b0;
      de_run  <= '0;
      de_seen <= 1'b0;
      hs_hist <= '0;
      de_hist <= '0;
    end else begin
      // a reprogrammed or overrun line is no full period; wait for a clean one
      if (state_next.regs != state_reg.regs) begin
        hs_seen <= 1'b0;
        de_seen <= 1'b0;
      end else if (i_char_en) begin
        if (state_next.hsync && !state_reg.hsync) begin
          hs_seen <= (state_next.hcnt <= hlast);
        end
        if (state_next.hcnt == 9'h000) begin
          de_seen <= 1'b1;
        end
      end
      if (i_char_en) begin
        if (state_next.hsync && !state_reg.hsync) begin
          hs_gap <= 9'h001;
        end else begin
          hs_gap <= 9'(hs_gap + 9'h001);
        end
        de_run  <= state_next.hde ? 9'(de_run + 9'h001) : '0;
        hs_hist <= {hs_hist[SKEW_DEPTH-2:0], state_reg.hsync};
        de_hist <= {de_hist[SKEW_DEPTH-2:0], state_reg.hde};
      end
    end
  end

  hsync_period_a: assert property (
    (i_char_en && state_next.hsync && !state_reg.hsync && hs_seen && !i_io_wr && $stable(state_reg.regs))
      |-> (hs_gap == 9'(hlast + 9'h001)))
    else $error("hsync period differs from total plus five");

  counter_wrap_a: assert property (
    line_end |=> (state_reg.hcnt == 9'h000))
    else $error("character counter did not restart at line end");

  de_length_a: assert property (
    (i_char_en && de_seen && state_reg.hde && !state_next.hde && !i_io_wr)
      |-> (de_run == 9'({1'b0, state_reg.regs[IDX_HDE[2:0]]} + 9'h001)))
    else $error("active display length wrong");

  blank_start_a: assert property (
    (i_char_en && state_next.hcnt == {1'b0, state_reg.regs[IDX_HBS[2:0]]}) |=> !o_blank_n)
    else $error("blank not asserted at blank start");

  hsync_start_a: assert property (
    (i_char_en && state_next.hcnt == {1'b0, state_reg.regs[IDX_HSS[2:0]]}) |=> state_reg.hsync)
    else $error("hsync not active at sync start");

  hsync_end_a: assert property (
    (i_char_en && state_next.hcnt[4:0] == state_reg.regs[IDX_HSE[2:0]][4:0]
      && state_next.hcnt != {1'b0, state_reg.regs[IDX_HSS[2:0]]}) |=> !state_reg.hsync)
    else $error("hsync not released at sync end");

  skew_zero_a: assert property (
    (hsync_skew == 2'h0) |-> (o_hsync == state_reg.hsync))
    else $error("unskewed hsync differs from raw hsync");

  write_lock_a: assert property (
    (i_timing_write_lock && i_io_wr && data_mapped && state_reg.idx[4:0] != IDX_VOVF)
      |=> $stable(state_reg.regs))
    else $error("locked timing register was written");

  panel_lock_a: assert property (
    (i_panel_lock && i_io_wr && data_mapped)
      |=> (state_reg.regs[IDX_HDE[2:0]] == $past(state_reg.regs[IDX_HDE[2:0]])
           && state_reg.regs[IDX_VOVF[2:0]][OVF_VDE9_BIT] == $past(state_reg.regs[IDX_VOVF[2:0]][OVF_VDE9_BIT])))
    else $error("panel lock did not hold display end");

  index_decode_a: assert property (
    (i_io_wr && i_io_addr == (i_color_sel ? IO_MONO_INDEX : IO_COLOR_INDEX))
      |=> $stable(state_reg.idx))
    else $error("index written through the unselected range");

  index_reserved_a: assert property (
    state_reg.idx[7:5] == 3'h0)
    else $error("reserved index bits not zero");

  readback_a: assert property (
    (i_io_rd && data_mapped) |=> (o_io_ack && o_io_rdata == $past(state_reg.regs[ridx])))
    else $error("read did not return stored value");

  vtotal_map_a: assert property (
    o_vtotal[9:8] == {state_reg.regs[IDX_VOVF[2:0]][OVF_VT9_BIT],
                      state_reg.regs[IDX_VOVF[2:0]][OVF_VT8_BIT]})
    else $error("vertical total overflow bits misplaced");

  frame_wrap_a: assert property (
    o_frame_start |-> (state_reg.vcnt == 12'h000))
    else $error("frame start without line counter wrap");

  hsync_skew_a: assert property (
    (hsync_skew != 2'h0) |-> (o_hsync == hs_hist[hsync_skew - 2'h1]))
    else $error("skewed hsync does not follow its delay");

  de_skew_a: assert property (
    (de_skew != 2'h0) |-> (o_display_en == de_hist[de_skew - 2'h1]))
    else $error("skewed display enable does not follow its delay");

  de_clamp_a: assert property (
    (state_reg.regs[IDX_HBE[2:0]][SKEW_LSB+1:SKEW_LSB] == 2'h3) |-> (o_display_en == de_hist[1]))
    else $error("display enable skew code three is not two clocks");

  index_write_a: assert property (
    (i_io_wr && sel_index) |=> (state_reg.idx == ($past(i_io_wdata) & INDEX_MASK)))
    else $error("index port did not keep the written index");

  refused_read_a: assert property (
    (i_io_rd && sel_data && state_reg.idx[4:0] >= 5'(NUM_REGS)) |=> !o_io_ack)
    else $error("read of an undecoded index was answered");

  line_cover_c:  cover property (line_end ##1 !line_end [*2] ##1 state_reg.hsync);
  frame_cover_c: cover property (o_frame_start);
  lock_cover_c:  cover property (i_timing_write_lock && i_io_wr && data_mapped);
  skew_cover_c:  cover property (hsync_skew == 2'h3 && o_hsync);
endmodule // vct_timing

// File: rtl/vct_pkg.sv
// constants for the crt horizontal timing block and its index/data port pair
package vct_pkg;
  // legacy i/o port addresses; colour/mono select picks the range
  localparam logic [15:0] IO_MONO_INDEX  = 16'h03b4;
  localparam logic [15:0] IO_MONO_DATA   = 16'h03b5;
  localparam logic [15:0] IO_COLOR_INDEX = 16'h03d4;
  localparam logic [15:0] IO_COLOR_DATA  = 16'h03d5;

  localparam int          NUM_REGS    = 8;
  localparam logic [7:0]  INDEX_MASK  = 8'h1f;
  localparam logic [7:0]  INDEX_RESET = 8'h00;
  localparam logic [7:0]  REG_RESET   = 8'h00;

  localparam logic [4:0]  IDX_HTOTAL  = 5'h00;
  localparam logic [4:0]  IDX_HDE     = 5'h01;
  localparam logic [4:0]  IDX_HBS     = 5'h02;
  localparam logic [4:0]  IDX_HBE     = 5'h03;
  localparam logic [4:0]  IDX_HSS     = 5'h04;
  localparam logic [4:0]  IDX_HSE     = 5'h05;
  localparam logic [4:0]  IDX_VTOTAL  = 5'h06;
  localparam logic [4:0]  IDX_VOVF    = 5'h07;

  // field positions
  localparam int SKEW_LSB      = 5;
  localparam int HBE_MSB_BIT   = 7;
  localparam int OVF_VSS9_BIT  = 7;
  localparam int OVF_VDE9_BIT  = 6;
  localparam int OVF_VT9_BIT   = 5;
  localparam int OVF_LC8_BIT   = 4;
  localparam int OVF_VBS8_BIT  = 3;
  localparam int OVF_VSS8_BIT  = 2;
  localparam int OVF_VDE8_BIT  = 1;
  localparam int OVF_VT8_BIT   = 0;

  // write masks under the two locks
  localparam logic [7:0]  WMASK_ALL     = 8'hff;
  localparam logic [7:0]  WMASK_NONE    = 8'h00;
  localparam logic [7:0]  WMASK_LOCKED7 = 8'h10;

  // timing offsets
  localparam logic [8:0]  HTOTAL_ADD = 9'h005;
  localparam logic [11:0] VTOTAL_ADD = 12'h002;
  localparam logic [1:0]  DE_SKEW_MAX = 2'h2;
  localparam int          SKEW_DEPTH  = 3;
endpackage

// File: rtl/vct_skew.sv
// character-clock delay line with selectable tap
`timescale 1ns/10ps
module vct_skew #(
  parameter int DEPTH = 3
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_char_en,
  input  wire logic       i_din,
  input  wire logic [1:0] i_sel,
  output logic            o_dout
);
  typedef struct packed {
    logic [DEPTH-1:0] pipe;
  } vct_skew_s;

  vct_skew_s state_reg;
  vct_skew_s state_next;

  always_comb begin
    state_next = state_reg;
    if (i_char_en) begin
      state_next.pipe = {state_reg.pipe[DEPTH-2:0], i_din};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // tap zero is the undelayed input, which is already a flip-flop upstream
  always_comb begin
    if (i_sel == 2'h0) begin
      o_dout = i_din;
    end else if (int'(i_sel) > DEPTH) begin
      o_dout = state_reg.pipe[DEPTH-1];
    end else begin
      o_dout = state_reg.pipe[int'(i_sel) - 1];
    end
  end
endmodule // vct_skew

// File: dv/vct_host.sv
// host processor model driving the legacy i/o port pair
`timescale 1ns/10ps
module vct_host (
  input  wire logic        i_sys_clk,
  input  wire logic        i_color_sel,
  input  wire logic        i_io_ack,
  input  wire logic [7:0]  i_io_rdata,
  output logic [15:0]      o_io_addr,
  output logic             o_io_wr,
  output logic             o_io_rd,
  output logic [7:0]       o_io_wdata
);
  import vct_pkg::*;
  initial begin
    o_io_addr  = 16'hfc2b;
    o_io_wr    = 1'b0;
    o_io_rd    = 1'b0;
    o_io_wdata = 8'h00;
  end
  // one-cycle strobe; answer is taken at the next falling edge
  task automatic cycle(input logic [15:0] a, input logic w, input logic [7:0] d,
                       output logic ack, output logic [7:0] q);
    @(negedge i_sys_clk);
    o_io_addr  <= a;
    o_io_wr    <= w;
    o_io_rd    <= !w;
    o_io_wdata <= d;
    @(negedge i_sys_clk);
    ack = i_io_ack;
    q   = i_io_rdata;
    // released bus shows an undecodable address, not the last one
    o_io_addr  <= 16'hfc2b;
    o_io_wr    <= 1'b0;
    o_io_rd    <= 1'b0;
    o_io_wdata <= ~d;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic       a;
    logic [7:0] q;
    cycle(i_color_sel ? IO_COLOR_INDEX : IO_MONO_INDEX, 1'b1, idx, a, q);
    cycle(i_color_sel ? IO_COLOR_DATA : IO_MONO_DATA, 1'b1, d, a, q);
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic ack, output logic [7:0] q);
    cycle(i_color_sel ? IO_COLOR_INDEX : IO_MONO_INDEX, 1'b1, idx, ack, q);
    cycle(i_color_sel ? IO_COLOR_DATA : IO_MONO_DATA, 1'b0, 8'h00, ack, q);
  endtask
endmodule // vct_host

// File: dv/vct_timing_tb.sv
// self-checking bench for the crt timing block
`timescale 1ns/10ps
module vct_timing_tb;
  import vct_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        char_en = 1'b0;
  logic        color_sel = 1'b1;
  logic        panel_lock = 1'b0;
  logic        wlock = 1'b0;
  logic        vt10 = 1'b0;
  logic        hit_q = 1'b0;
  logic [15:0] addr;
  logic        wr, rd, hit, ack, hs, blank_n, de, fs, vblank_start_high_bit, lc;
  logic [7:0]  wdata, rdata;
  logic [11:0] lines;
  logic [10:0] vtot;
  logic [9:0]  vss, vdisplay_end_high_bit;
  int          n_fail, cmp_count;
  always #2.5 clk = ~clk;
  vct_timing vct_timing_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_char_en(char_en), .i_color_sel(color_sel),
    .i_panel_lock(panel_lock), .i_timing_write_lock(wlock), .i_vtotal_bit10(vt10), .i_io_addr(addr),
    .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_hit(hit), .o_io_rdata(rdata), .o_io_ack(ack),
    .o_hsync(hs), .o_blank_n(blank_n), .o_display_en(de), .o_frame_start(fs), .o_line_count(lines),
    .o_vtotal(vtot), .o_vsync_start_high(vss), .o_vdisplay_end_high(vdisplay_end_high_bit), .o_vblank_start_high_bit(vblank_start_high_bit),
    .o_line_compare_high_bit(lc));
  vct_host vct_host_inst (.i_sys_clk(clk), .i_color_sel(color_sel), .i_io_ack(ack), .i_io_rdata(rdata),
    .o_io_addr(addr), .o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wdata));
  // hit as the design showed it during the last read strobe
  always @(posedge clk) begin
    if (rd) begin
      hit_q <= hit;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic       a;
    logic [7:0] q;
    vct_host_inst.rd_reg(idx, a, q);
    check({a, q}, {1'b1, exp});
    check(hit_q, 1'b1);
  endtask
  // waits for a rising hsync, counts one line and discards it, then counts the next line on a free-running char clock
  task automatic measure(output int per, output int del, output int off, output int blk, output int hsw);
    logic p;
    for (int n = 0; n < 3; n++) begin
      per = 0;
      del = 0;
      off = -1;
      blk = 0;
      hsw = 0;
      p = 1'b1;
      do begin
        if (n == 2 && de === 1'b1 && off < 0) off = per;
        del += (de === 1'b1);
        blk += (blank_n === 1'b0);
        hsw += (hs === 1'b1);
        p = hs;
        @(negedge clk);
        per++;
      end while (!(hs === 1'b1 && p === 1'b0) && per < 600);
      if (per >= 600) begin
        check(16'h0, 16'h1);
      end
    end
  endtask
  task automatic ovf_case(input logic [7:0] v, input logic [15:0] t, input logic [15:0] s,
                          input logic [15:0] e, input logic b, input logic l);
    vct_host_inst.wr_reg(8'h07, v);
    check(vtot, t);
    check(vss, s);
    check(vdisplay_end_high_bit, e);
    check({vblank_start_high_bit, lc}, {b, l});
  endtask
  initial begin
    logic       a;
    logic [7:0] q;
    int         per, del, off, blk, hsw;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    char_en = 1'b1;
    vct_host_inst.cycle(IO_COLOR_INDEX, 1'b0, 8'h00, a, q);
    check(q, INDEX_RESET);
    for (int i = 0; i < NUM_REGS; i++) rd_chk(i[7:0], REG_RESET);
    // reserved index bits set on every write
    for (int i = 0; i < NUM_REGS; i++) vct_host_inst.wr_reg(8'he0 | i[7:0], {~i[3:0], i[3:0]});
    for (int i = 0; i < NUM_REGS; i++) rd_chk(i[7:0], {~i[3:0], i[3:0]});
    vct_host_inst.cycle(IO_COLOR_INDEX, 1'b0, 8'h00, a, q);
    check(q, 8'h07);
    vct_host_inst.rd_reg(8'h08, a, q);
    check(a, 1'b0);
    check(hit_q, 1'b0);
    color_sel = 1'b0;
    vct_host_inst.wr_reg(8'h02, 8'h3c);
    vct_host_inst.cycle(IO_COLOR_DATA, 1'b1, 8'hff, a, q);
    rd_chk(8'h02, 8'h3c);
    color_sel = 1'b1;
    vct_host_inst.cycle(IO_MONO_DATA, 1'b1, 8'h99, a, q);
    rd_chk(8'h02, 8'h3c);
    wlock = 1'b1;
    vct_host_inst.wr_reg(8'h00, 8'haa);
    vct_host_inst.wr_reg(8'h07, 8'hff);
    wlock = 1'b0;
    rd_chk(8'h00, 8'hf0);
    rd_chk(8'h07, 8'h97);
    vct_host_inst.wr_reg(8'h07, 8'hff);
    panel_lock = 1'b1;
    vct_host_inst.wr_reg(8'h01, 8'h00);
    vct_host_inst.wr_reg(8'h07, 8'h00);
    panel_lock = 1'b0;
    rd_chk(8'h01, 8'he1);
    rd_chk(8'h07, 8'h40);
    vt10 = 1'b1;
    vct_host_inst.wr_reg(8'h06, 8'h12);
    ovf_case(8'hb2, 16'h0612, 16'h0200, 16'h0100, 1'b0, 1'b1);
    ovf_case(8'h4d, 16'h0512, 16'h0100, 16'h0200, 1'b1, 1'b0);
    vt10 = 1'b0;
    vct_host_inst.wr_reg(8'h00, 8'd35);
    vct_host_inst.wr_reg(8'h01, 8'd19);
    vct_host_inst.wr_reg(8'h02, 8'd33);
    vct_host_inst.wr_reg(8'h04, 8'd30);
    vct_host_inst.wr_reg(8'h06, 8'h01);
    vct_host_inst.wr_reg(8'h07, 8'h00);
    // blank end is 34: needs the msb held in the sync end register
    for (int k = 0; k < 4; k++) begin
      vct_host_inst.wr_reg(8'h03, {1'b0, 2'(3 - k), 5'h02});
      vct_host_inst.wr_reg(8'h05, {1'b1, 2'(k), 5'h02});
      measure(per, del, off, blk, hsw);
      check(16'(per), 16'd40);
      check(16'(del), 16'd20);
      check(16'(blk), 16'd1);
      check(16'(hsw), 16'd4);
      check(16'(off), 16'(10 + ((3 - k) > 2 ? 2 : (3 - k)) - k));
    end
    per = 0;
    while (fs !== 1'b1 && per < 400) begin
      @(negedge clk);
      per++;
    end
    check(16'(per < 400), 16'h1);
    per = 0;
    do begin
      @(negedge clk);
      per++;
    end while (fs !== 1'b1 && per < 400);
    check(16'(per), 16'd120);
    check(16'(lines), 16'h000);
    print_verdict();
  end
endmodule // vct_timing_tb
